//--- src/gpio6_consts.svh
// Purpose: constants for the six-pin general-purpose port
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: reserved bits read as zero except the fixed direction bit
// Summary of operation
// - six pins, each with direction, latch, drain, slew, threshold bits; analog bits on pins 0-2 and 4 only
// - direction 1 makes the pin input; 0 drives the latch onto the pin
// - pin 3 is input-only; its direction bit always reads 1
// - pin-level reads return sampled pins; writes go to the output latch
// - latch writes act like pin-level writes; latch reads return latch values
// - pin-level writes store the written bits straight into the output latch
// - direction bits still control drivers on analog pins
// - analog pins read zero on every digital read
// - analog select disables the digital input buffer
// - analog select leaves digital output functions untouched
// - analog select bits reset to analog
// - open-drain bit makes the output sink only, else push-pull
// - slew bit limits output slew rate, else maximum rate
// - threshold bit picks Schmitt or TTL for reads and pin-change detection
// - an enabled peripheral takes over the output; pin stays readable
// - after reset outputs follow the latch; peripherals attach via pin select
// - pull-up only when its bit set, global disable clear, pin input
`ifndef GPIO6_CONSTS_SVH
`define GPIO6_CONSTS_SVH
`define GP6_ADDR_LEVEL 4'h0
`define GP6_ADDR_DIR 4'h1
`define GP6_ADDR_LATCH 4'h2
`define GP6_ADDR_ANSEL 4'h3
`define GP6_ADDR_ODRAIN 4'h4
`define GP6_ADDR_SLEW 4'h5
`define GP6_ADDR_THRESH 4'h6
`define GP6_ADDR_PULLUP 4'h7
`define GP6_ADDR_GLOBAL 4'h8
`define GP6_ADDR_PERIPH 4'h9
`define GP6_INPUT_ONLY_PIN 3
`define GP6_RST_DIR 6'h3f
`define GP6_RST_LATCH 6'h00
`define GP6_RST_ANSEL 6'h17
`define GP6_ANSEL_MASK 6'h17
`define GP6_RST_ODRAIN 6'h00
`define GP6_RST_SLEW 6'h37
`define GP6_RST_THRESH 6'h00
`define GP6_RST_PULLUP 6'h3f
`define GP6_RST_GLOBAL 1'b1
`define GP6_RST_PERIPH 6'h00
`define GP6_RESP_OKAY 2'b00
`define GP6_RESP_SLVERR 2'b10
`endif

//--- src/gpio6_pkg.sv
// Purpose: types for the six-pin general-purpose port
// Assumes: nothing beyond the constants header
// Notes: bus channel states
package gpio6_pkg;
	typedef enum logic [1:0] {
		GP6_W_IDLE,
		GP6_W_HAVE_ADDR,
		GP6_W_HAVE_DATA,
		GP6_W_RESP
	} gpio6_wstate_t;
endpackage : gpio6_pkg

//--- src/gpio6_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: one clock, synchronous active-high reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module gpio6_sync #(
	parameter int WIDTH = 6
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= async_i;
			stage2_reg <= stage1_reg;
		end
	end
	assign sync_o = stage2_reg;
endmodule : gpio6_sync
`default_nettype wire

//--- src/gpio6_pin.sv
// Purpose: drive and input conditioning for one pin
// Assumes: pad cell reads the slew and threshold selects
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module gpio6_pin (
	input wire logic dir_in_i,
	input wire logic latch_i,
	input wire logic ansel_i,
	input wire logic odrain_i,
	input wire logic slew_i,
	input wire logic thresh_i,
	input wire logic pullup_i,
	input wire logic pullup_off_i,
	input wire logic periph_en_i,
	input wire logic periph_data_i,
	input wire logic pad_sync_i,
	output logic pad_o,
	output logic pad_oe_o,
	output logic pad_slew_o,
	output logic pad_schmitt_o,
	output logic pad_pullup_o,
	output logic pad_ibuf_en_o,
	output logic digital_in_o
);
	logic drive_val;
	// peripheral overrides the latch only when selected
	assign drive_val = periph_en_i ? periph_data_i : latch_i;
	assign pad_o = drive_val;
	// open drain never drives high, it releases instead
	assign pad_oe_o = !dir_in_i && !(odrain_i && drive_val);
	assign pad_slew_o = slew_i;
	assign pad_schmitt_o = !thresh_i;
	assign pad_pullup_o = pullup_i && !pullup_off_i && dir_in_i;
	assign pad_ibuf_en_o = !ansel_i;
	assign digital_in_o = ansel_i ? 1'b0 : pad_sync_i;
endmodule : gpio6_pin
`default_nettype wire

//--- src/gpio6_port.sv
// Purpose: six-pin general-purpose port with AXI4-Lite registers
// Assumes: pads sampled on ref_clk_i through two flops
// Notes: one write and one read outstanding; unmapped access gets SLVERR
`timescale 1ns/1ps
`default_nettype none
`include "gpio6_consts.svh"
module gpio6_port
	import gpio6_pkg::*;
#(
	parameter int PINS = 6
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PINS-1:0] pad_i,
	output logic [PINS-1:0] pad_o,
	output logic [PINS-1:0] pad_oe_o,
	output logic [PINS-1:0] pad_slew_o,
	output logic [PINS-1:0] pad_schmitt_o,
	output logic [PINS-1:0] pad_pullup_o,
	output logic [PINS-1:0] pad_ibuf_en_o,
	output logic [PINS-1:0] pin_change_level_o,
	input wire logic [PINS-1:0] periph_data_i
);
	logic [PINS-1:0] dir_reg;
	logic [PINS-1:0] latch_reg;
	logic [PINS-1:0] ansel_reg;
	logic [PINS-1:0] odrain_reg;
	logic [PINS-1:0] slew_reg;
	logic [PINS-1:0] thresh_reg;
	logic [PINS-1:0] pullup_reg;
	logic global_pullup_off_reg;
	logic [PINS-1:0] periph_en_reg;
	logic [PINS-1:0] pad_sync;
	logic [PINS-1:0] level_in;
	logic [PINS-1:0] dir_eff;
	gpio6_wstate_t wstate_reg;
	logic [3:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic wmapped;
	logic [PINS-1:0] wbits;
	logic [PINS-1:0] rmw_base;
	logic [31:0] rdata_next;
	logic rmapped;

	gpio6_sync #(
		.WIDTH(PINS)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(pad_i),
		.sync_o(pad_sync)
	);

	// pin 3 has no output driver at all
	always_comb begin
		dir_eff = dir_reg;
		dir_eff[`GP6_INPUT_ONLY_PIN] = 1'b1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			gpio6_pin u_pin (
				.dir_in_i(dir_eff[gi]),
				.latch_i(latch_reg[gi]),
				.ansel_i(ansel_reg[gi]),
				.odrain_i(odrain_reg[gi]),
				.slew_i(slew_reg[gi]),
				.thresh_i(thresh_reg[gi]),
				.pullup_i(pullup_reg[gi]),
				.pullup_off_i(global_pullup_off_reg),
				.periph_en_i(periph_en_reg[gi]),
				.periph_data_i(periph_data_i[gi]),
				.pad_sync_i(pad_sync[gi]),
				.pad_o(pad_o[gi]),
				.pad_oe_o(pad_oe_o[gi]),
				.pad_slew_o(pad_slew_o[gi]),
				.pad_schmitt_o(pad_schmitt_o[gi]),
				.pad_pullup_o(pad_pullup_o[gi]),
				.pad_ibuf_en_o(pad_ibuf_en_o[gi]),
				.digital_in_o(level_in[gi])
			);
		end
	endgenerate

	// change detector sees the same conditioned level as reads
	assign pin_change_level_o = level_in;

	// write channel: address and data in either order
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wstate_reg <= GP6_W_IDLE;
			waddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			case (wstate_reg)
				GP6_W_IDLE: begin
					if (s_axi_awvalid) begin
						waddr_reg <= s_axi_awaddr[5:2];
					end
					if (s_axi_wvalid) begin
						wdata_reg <= s_axi_wdata;
						wstrb_reg <= s_axi_wstrb;
					end
					if (s_axi_awvalid && s_axi_wvalid) begin
						wstate_reg <= GP6_W_RESP;
					end else if (s_axi_awvalid) begin
						wstate_reg <= GP6_W_HAVE_ADDR;
					end else if (s_axi_wvalid) begin
						wstate_reg <= GP6_W_HAVE_DATA;
					end
				end
				GP6_W_HAVE_ADDR: begin
					if (s_axi_wvalid) begin
						wdata_reg <= s_axi_wdata;
						wstrb_reg <= s_axi_wstrb;
						wstate_reg <= GP6_W_RESP;
					end
				end
				GP6_W_HAVE_DATA: begin
					if (s_axi_awvalid) begin
						waddr_reg <= s_axi_awaddr[5:2];
						wstate_reg <= GP6_W_RESP;
					end
				end
				GP6_W_RESP: begin
					if (s_axi_bready) begin
						wstate_reg <= GP6_W_IDLE;
					end
				end
				default: wstate_reg <= GP6_W_IDLE;
			endcase
		end
	end

	assign s_axi_awready = (wstate_reg == GP6_W_IDLE)
		|| (wstate_reg == GP6_W_HAVE_DATA);
	assign s_axi_wready = (wstate_reg == GP6_W_IDLE)
		|| (wstate_reg == GP6_W_HAVE_ADDR);
	assign s_axi_bvalid = (wstate_reg == GP6_W_RESP);
	assign wmapped = (waddr_reg <= `GP6_ADDR_PERIPH);
	assign s_axi_bresp = wmapped ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR;

	// registers commit once as the response is accepted
	assign do_write = s_axi_bvalid && s_axi_bready && wstrb_reg[0];
	assign wbits = wdata_reg[PINS-1:0];
	// rmw: base is the sampled pin value, but every latch bit ends up as written
	assign rmw_base = level_in;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			latch_reg <= `GP6_RST_LATCH;
		end else if (do_write && (waddr_reg == `GP6_ADDR_LEVEL)) begin
			// written byte overrides every bit of the read pin image
			latch_reg <= (rmw_base & ~(rmw_base ^ wbits)) | wbits;
		end else if (do_write && (waddr_reg == `GP6_ADDR_LATCH)) begin
			latch_reg <= wbits;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			dir_reg <= `GP6_RST_DIR;
		end else if (do_write && (waddr_reg == `GP6_ADDR_DIR)) begin
			dir_reg <= wbits;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ansel_reg <= `GP6_RST_ANSEL;
		end else if (do_write && (waddr_reg == `GP6_ADDR_ANSEL)) begin
			ansel_reg <= wbits & `GP6_ANSEL_MASK;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			odrain_reg <= `GP6_RST_ODRAIN;
			slew_reg <= `GP6_RST_SLEW;
			thresh_reg <= `GP6_RST_THRESH;
		end else if (do_write) begin
			if (waddr_reg == `GP6_ADDR_ODRAIN) begin
				odrain_reg <= wbits;
			end
			if (waddr_reg == `GP6_ADDR_SLEW) begin
				slew_reg <= wbits;
			end
			// no guard against live peripherals; software's duty
			if (waddr_reg == `GP6_ADDR_THRESH) begin
				thresh_reg <= wbits;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pullup_reg <= `GP6_RST_PULLUP;
			global_pullup_off_reg <= `GP6_RST_GLOBAL;
			periph_en_reg <= `GP6_RST_PERIPH;
		end else if (do_write) begin
			if (waddr_reg == `GP6_ADDR_PULLUP) begin
				pullup_reg <= wbits;
			end
			if (waddr_reg == `GP6_ADDR_GLOBAL) begin
				global_pullup_off_reg <= wbits[0];
			end
			if (waddr_reg == `GP6_ADDR_PERIPH) begin
				periph_en_reg <= wbits;
			end
		end
	end

	// read channel
	assign rmapped = (s_axi_araddr[5:2] <= `GP6_ADDR_PERIPH);
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (s_axi_araddr[5:2])
			`GP6_ADDR_LEVEL: rdata_next[PINS-1:0] = level_in;
			`GP6_ADDR_DIR: rdata_next[PINS-1:0] = dir_eff;
			`GP6_ADDR_LATCH: rdata_next[PINS-1:0] = latch_reg;
			`GP6_ADDR_ANSEL: rdata_next[PINS-1:0] = ansel_reg;
			`GP6_ADDR_ODRAIN: rdata_next[PINS-1:0] = odrain_reg;
			`GP6_ADDR_SLEW: rdata_next[PINS-1:0] = slew_reg;
			`GP6_ADDR_THRESH: rdata_next[PINS-1:0] = thresh_reg;
			`GP6_ADDR_PULLUP: rdata_next[PINS-1:0] = pullup_reg;
			`GP6_ADDR_GLOBAL: rdata_next[0] = global_pullup_off_reg;
			`GP6_ADDR_PERIPH: rdata_next[PINS-1:0] = periph_en_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `GP6_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rmapped ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	a_input_only_dir: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i) !pad_oe_o[`GP6_INPUT_ONLY_PIN])
		else $error("input-only pin is driven");
	a_dir_gates_oe: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i) dir_eff[0] |-> !pad_oe_o[0])
		else $error("input pin 0 is driven");
	a_analog_reads_0: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i) (ansel_reg & level_in) == '0)
		else $error("analog pin reads nonzero");
	a_ibuf_off: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i) (ansel_reg & pad_ibuf_en_o) == '0)
		else $error("input buffer left on for analog pin");
	a_pullup_gate: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i)
		pad_pullup_o[1] |-> (dir_eff[1] && !global_pullup_off_reg))
		else $error("pull-up active when not allowed");
	a_odrain_high: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i)
		(odrain_reg[0] && pad_o[0]) |-> !pad_oe_o[0])
		else $error("open-drain pin drives high");
	sequence s_latch_write;
		do_write && (waddr_reg == `GP6_ADDR_LATCH);
	endsequence
	a_latch_update: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i)
		s_latch_write |=> (latch_reg == $past(wbits)))
		else $error("latch write not stored");
	// synchroniser holds reset zeros for two edges after release
	a_sync_delay: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i)
		(!$past(sys_rst_i) && !$past(sys_rst_i, 2) && !ansel_reg[5])
		|-> (level_in[5] == $past(pad_i[5], 2)))
		else $error("pin level not two cycles late");
	a_periph_drive: assert property (@(posedge ref_clk_i)
		disable iff (sys_rst_i)
		periph_en_reg[0] |-> (pad_o[0] == periph_data_i[0]))
		else $error("peripheral not driving pin");
endmodule : gpio6_port
`default_nettype wire

//--- sim/gpio6_board.sv
// Purpose: board-side pin model for the six-pin port
// Assumes: the bench picks which pins it drives and to what level
// Notes: floating pins toggle every cycle so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module gpio6_board (
	input wire logic ref_clk_i,
	input wire logic [5:0] pad_o_i,
	input wire logic [5:0] pad_oe_i,
	input wire logic [5:0] pullup_i,
	input wire logic [5:0] ext_en_i,
	input wire logic [5:0] ext_val_i,
	output logic [5:0] level_o
);
	logic [5:0] float_reg = 6'h15;

	always_ff @(posedge ref_clk_i) begin
		float_reg <= ~float_reg;
	end

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (pad_oe_i[i])
				level_o[i] = pad_o_i[i];
			else if (ext_en_i[i])
				level_o[i] = ext_val_i[i];
			else if (pullup_i[i])
				level_o[i] = 1'b1;
			else
				level_o[i] = float_reg[i];
		end
	end
endmodule : gpio6_board
`default_nettype wire

//--- sim/testbench.sv
// Purpose: self-checking bench for the six-pin port
// Assumes: AXI4-Lite master tasks, board model on the pads
// Notes: lfsr stimulus; expectations from a register model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int MSK[10] = '{6'h3f, 6'h3f, 6'h3f, 6'h17, 6'h3f, 6'h37,
		6'h3f, 6'h3f, 6'h01, 6'h3f};
	localparam int RST[10] = '{6'h00, 6'h3f, 6'h00, 6'h17, 6'h00, 6'h37,
		6'h00, 6'h3f, 6'h01, 6'h00};
	logic ref_clk_i = 0;
	logic sys_rst_i = 1;
	logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [5:0] pad_i, pad_o, pad_oe_o, pad_slew_o, pad_schmitt_o;
	logic [5:0] pad_pullup_o, pad_ibuf_en_o, pin_change_level_o;
	logic [5:0] periph_data_i = 0, ext_en = 6'h3f, ext_val = 0;
	int num_errors = 0;
	int n_compared = 0;
	int m_reg[10];
	logic [31:0] seed = 32'h7875;

	always #5 ref_clk_i = ~ref_clk_i;

	gpio6_port DUT (.ref_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_i, .pad_o,
		.pad_oe_o, .pad_slew_o, .pad_schmitt_o, .pad_pullup_o,
		.pad_ibuf_en_o, .pin_change_level_o, .periph_data_i);
	gpio6_board board (.ref_clk_i, .pad_o_i(pad_o), .pad_oe_i(pad_oe_o),
		.pullup_i(pad_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.level_o(pad_i));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int i = 0; i < 32; i++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : lfsr

	task automatic wrap_up;
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic cmp(input string nm, input logic [31:0] e, g, m);
		n_compared++;
		if ((g & m) !== (e & m)) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask : cmp

	task automatic exp_pads(output logic [5:0] dv, oe, pu, lv, kn);
		for (int i = 0; i < 6; i++) begin
			dv[i] = m_reg[9][i] ? periph_data_i[i] : m_reg[2][i];
			oe[i] = !m_reg[1][i] && !(m_reg[4][i] && dv[i]);
			pu[i] = m_reg[7][i] && !m_reg[8][0] && m_reg[1][i];
			lv[i] = (oe[i] ? dv[i] : ext_en[i] ? ext_val[i] : 1'b1)
				&& !m_reg[3][i];
			kn[i] = oe[i] || ext_en[i] || pu[i] || m_reg[3][i];
		end
	endtask : exp_pads

	// sampled at the falling edge so the launching edge has settled
	task automatic check_pads;
		logic [5:0] dv, oe, pu, lv, kn;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		exp_pads(dv, oe, pu, lv, kn);
		cmp("pad_oe", oe, pad_oe_o, 6'h3f);
		cmp("pad_o", dv, pad_o, oe);
		cmp("slew", m_reg[5], pad_slew_o, 6'h37);
		cmp("schmitt", ~m_reg[6], pad_schmitt_o, 6'h3f);
		cmp("pullup", pu, pad_pullup_o, 6'h3f);
		cmp("ibuf", ~m_reg[3], pad_ibuf_en_o, 6'h3f);
		cmp("change_level", lv, pin_change_level_o, kn);
		@(posedge ref_clk_i);
	endtask : check_pads

	task automatic wr(input int idx, input logic [31:0] d, input logic [3:0] s);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] br;
		int t;
		aw_ok = 0;
		w_ok = 0;
		b_ok = 0;
		br = 0;
		t = 0;
		s_axi_awaddr <= 6'(idx * 4);
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!b_ok && t < 50) begin
			@(negedge ref_clk_i);
			if (s_axi_awvalid && s_axi_awready) aw_ok = 1;
			if (s_axi_wvalid && s_axi_wready) w_ok = 1;
			if (s_axi_bvalid) begin
				b_ok = 1;
				br = s_axi_bresp;
			end
			@(posedge ref_clk_i);
			if (aw_ok) s_axi_awvalid <= 0;
			if (w_ok) s_axi_wvalid <= 0;
			if (b_ok) s_axi_bready <= 0;
			t++;
		end
		// idle edge so the next call never re-drives a just-released strobe
		@(posedge ref_clk_i);
		cmp("bvalid", 1, b_ok, 1);
		cmp("bresp", idx > 9 ? 2 : 0, br, 3);
		if (idx < 10 && s[0]) begin
			m_reg[idx == 0 ? 2 : idx] = d & MSK[idx];
			m_reg[1] |= 32'h8;
		end
	endtask : wr

	task automatic rd(input int idx);
		logic ar_ok, ok;
		logic [31:0] got;
		logic [1:0] rr;
		logic [5:0] dv, oe, pu, lv, kn;
		int t;
		ar_ok = 0;
		ok = 0;
		got = 0;
		rr = 0;
		t = 0;
		s_axi_araddr <= 6'(idx * 4);
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!ok && t < 50) begin
			@(negedge ref_clk_i);
			if (s_axi_arvalid && s_axi_arready) ar_ok = 1;
			if (s_axi_rvalid) begin
				ok = 1;
				got = s_axi_rdata;
				rr = s_axi_rresp;
			end
			@(posedge ref_clk_i);
			if (ar_ok) s_axi_arvalid <= 0;
			if (ok) s_axi_rready <= 0;
			t++;
		end
		@(posedge ref_clk_i);
		cmp("rvalid", 1, ok, 1);
		exp_pads(dv, oe, pu, lv, kn);
		cmp("rresp", idx > 9 ? 2 : 0, rr, 3);
		if (idx > 9)
			cmp("rdata", 0, got, '1);
		else if (idx == 0)
			cmp("level", lv, got, {26'h3ffffff, kn});
		else
			cmp("reg", m_reg[idx], got, '1);
	endtask : rd

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		num_errors++;
		wrap_up();
	end

	initial begin
		int k;
		logic [31:0] d;
		for (k = 0; k < 10; k++)
			m_reg[k] = RST[k];
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 0;
		@(posedge ref_clk_i);
		for (k = 1; k < 10; k++)
			rd(k);
		check_pads();
		// analog pins driven as outputs still follow the latch
		wr(2, 32'h15, 4'h1);
		wr(1, 32'h0, 4'h1);
		check_pads();
		rd(0);
		rd(1);
		wr(3, 32'h0, 4'h1);
		for (int n = 0; n < 80; n++) begin
			seed = lfsr(seed);
			ext_val <= seed[5:0];
			ext_en <= seed[11:6];
			periph_data_i <= seed[17:12];
			k = int'(seed[21:18]);
			d = {26'h0, seed[27:22]} & (k == 1 || k == 7 ? 32'h3f : 32'h37);
			if (k == 1) d = d | m_reg[3];
			if (k == 6) wr(9, 32'h0, 4'h1);
			wr(k, d, {3'h0, seed[29:28] != 2'h0});
			check_pads();
			rd(k);
			rd(0);
		end
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
